// >>> rtl/link_tx_regs_pkg.sv
// Package with register map, field layout, reset values and codes for the link control bank.
// What this block does
// RL1 - Writing zero to manual bit requests sync
// RL2 - Manual request works under any source select
// RL3 - Stuck-low pin releases only with select two or three
// RL4 - Select chooses sync pin, timestamp, or software only
// RL5 - Format bit: offset binary or two's complement
// RL6 - Scrambler enable bit, disabled at reset
// RL7 - Software writes accepted whether link enabled or disabled
// RL8 - Pattern 0 normal, 1-3 PRBS 7/15/23
// RL9 - Pattern 4 ramp, 5 transport, 6 D21.5, 7 K28.5
// RL10 - Pattern 8 repeated alignment, 9 modified random
// RL11 - Pattern 10 outputs low, 11 outputs high
// RL12 - Pattern codes 12 to 15 are reserved
// RL13 - Device identifier sent in second alignment multiframe
// RL14 - Link A sends identifier, link B plus one
// RL15 - Identifier low bit ignored, reads zero
// RL16 - Frame end select: K28.7, K28.1, K28.5, reserved
// RL17 - Link disabled holds transmitter in reset, powered down
// RL18 - Effective sync request is pin or manual bit
package link_tx_regs_pkg;
    localparam logic [11:0] link_enable_index = 12'h200;
    localparam logic [11:0] manual_sync_request_index = 12'h203;
    localparam logic [11:0] link_control_index = 12'h204;
    localparam logic [11:0] test_pattern_control_index = 12'h205;
    localparam logic [11:0] device_id_parameter_index = 12'h206;
    localparam logic [11:0] frame_end_character_index = 12'h207;
    localparam int addr_width = 14;

    localparam logic [7:0] link_enable_reset = 8'h01;
    localparam logic [7:0] manual_sync_request_reset = 8'h01;
    localparam logic [7:0] link_control_reset = 8'h02;
    localparam logic [7:0] test_pattern_control_reset = 8'h00;
    localparam logic [7:0] device_id_parameter_reset = 8'h00;
    localparam logic [7:0] frame_end_character_reset = 8'h00;

    localparam int link_enable_pos = 0;
    localparam int manual_sync_request_n_pos = 0;
    localparam int scrambler_enable_pos = 0;
    localparam int sample_format_pos = 1;
    localparam int sync_source_lsb = 2;
    localparam int test_pattern_lsb = 0;
    localparam int frame_char_lsb = 0;

    localparam logic [1:0] sync_src_pin = 2'h0;
    localparam logic [1:0] sync_src_timestamp = 2'h1;
    localparam logic [1:0] sync_src_software = 2'h2;

    typedef enum logic [3:0] {
        pat_normal = 4'h0,
        pat_prbs7 = 4'h1,
        pat_prbs15 = 4'h2,
        pat_prbs23 = 4'h3,
        pat_ramp = 4'h4,
        pat_transport = 4'h5,
        pat_d21_5 = 4'h6,
        pat_k28_5 = 4'h7,
        pat_repeat_ila = 4'h8,
        pat_mod_rpat = 4'h9,
        pat_hold_low = 4'ha,
        pat_hold_high = 4'hb
    } test_pattern_t;

    localparam logic [7:0] k28_7 = 8'hfc;
    localparam logic [7:0] k28_1 = 8'h3c;
    localparam logic [7:0] k28_5 = 8'hbc;
endpackage

// >>> rtl/sync_request_select.sv
// Combines the selected sync pin with the manual request into one active-low request.
`timescale 1ns/1ps
`default_nettype none
module sync_request_select (
    // Selection and software request
    input wire logic [1:0] source_select,
    input wire logic manual_sync_request_n,
    input wire logic timestamp_receiver_enable,
    // Pins, active low
    input wire logic single_ended_sync_pin_n,
    input wire logic differential_timestamp_input_n,
    // Result
    output logic sync_request_n
);
    logic pin_asserted;

    always_comb begin
        pin_asserted = 1'b0;
        case (source_select)
            link_tx_regs_pkg::sync_src_pin: begin
                pin_asserted = ~single_ended_sync_pin_n; // RL4
            end
            link_tx_regs_pkg::sync_src_timestamp: begin
                pin_asserted = timestamp_receiver_enable & ~differential_timestamp_input_n; // RL4
            end
            default: begin
                // A stuck pin is ignored under software-only selection and under the unused code 3.
                pin_asserted = 1'b0; // RL3
            end
        endcase
        sync_request_n = ~(pin_asserted | ~manual_sync_request_n); // RL18 RL1 RL2
    end
endmodule
`default_nettype wire

// >>> rtl/frame_char_select.sv
// Maps the end-of-frame select code to its control character.
`timescale 1ns/1ps
`default_nettype none
module frame_char_select (
    // Select code
    input wire logic [1:0] select_code,
    // Character and reserved flag
    output logic [7:0] char_code,
    output logic reserved_code
);
    always_comb begin
        reserved_code = 1'b0;
        case (select_code)
            2'h0: char_code = link_tx_regs_pkg::k28_7; // RL16
            2'h1: char_code = link_tx_regs_pkg::k28_1; // RL16
            2'h2: char_code = link_tx_regs_pkg::k28_5; // RL16
            default: begin
                // Reserved code falls back to the compliant character.
                char_code = link_tx_regs_pkg::k28_7;
                reserved_code = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> rtl/serial_link_tx_control_regs.sv
// AXI4-Lite register bank steering the serial link transmitter.
`timescale 1ns/1ps
`default_nettype none
module serial_link_tx_control_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [link_tx_regs_pkg::addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [link_tx_regs_pkg::addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sync pins, active low, and active-high timestamp receiver enable
    input wire logic single_ended_sync_pin_n,
    input wire logic differential_timestamp_input_n,
    input wire logic timestamp_receiver_enable,
    // Transmitter controls
    output logic link_enable,
    output logic transmitter_reset,
    output logic serializer_power_down,
    output logic tx_clock_gate_off,
    output logic multiframe_counter_reset,
    output logic sync_request_n,
    output logic sample_format,
    output logic scrambler_enable,
    output logic [3:0] test_pattern_select,
    output logic [7:0] link_a_device_identifier,
    output logic [7:0] link_b_device_identifier,
    output logic [7:0] end_of_frame_char,
    output logic end_of_frame_char_reserved,
    output logic test_pattern_reserved
);
    typedef struct packed {
        logic aw_held;
        logic [link_tx_regs_pkg::addr_width-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] enable_reg;
        logic [7:0] manual_reg;
        logic [7:0] control_reg;
        logic [7:0] pattern_reg;
        logic [7:0] did_reg;
        logic [7:0] end_of_frame_char_select_reg;
        logic sync_n;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic sync_comb_n;
    logic [7:0] end_of_frame_char_select_code;
    logic end_of_frame_char_select_reserved;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    sync_request_select sync_sel_inst (
        .source_select(state_reg.control_reg[link_tx_regs_pkg::sync_source_lsb +: 2]),
        .manual_sync_request_n(state_reg.manual_reg[link_tx_regs_pkg::manual_sync_request_n_pos]),
        .timestamp_receiver_enable(timestamp_receiver_enable),
        .single_ended_sync_pin_n(single_ended_sync_pin_n),
        .differential_timestamp_input_n(differential_timestamp_input_n),
        .sync_request_n(sync_comb_n)
    );

    frame_char_select end_of_frame_char_select_inst (
        .select_code(state_reg.end_of_frame_char_select_reg[link_tx_regs_pkg::frame_char_lsb +: 2]),
        .char_code(end_of_frame_char_select_code),
        .reserved_code(end_of_frame_char_select_reserved)
    );

    function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        merge_byte = strb[0] ? data[7:0] : old_value;
    endfunction

    function automatic logic [11:0] word_index(
        input logic [link_tx_regs_pkg::addr_width-1:0] addr);
        word_index = addr[link_tx_regs_pkg::addr_width-1:2];
    endfunction

    always_comb begin
        logic [11:0] idx;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic hit;
        idx = 12'h000;
        wbyte = 8'h00;
        rbyte = 8'h00;
        hit = 1'b0;
        state_next = state_reg;
        state_next.sync_n = sync_comb_n;

        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Both halves held and no response pending: commit the write.
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            idx = word_index(state_reg.aw_addr);
            hit = 1'b1;
            if (idx == link_tx_regs_pkg::link_enable_index) begin
                wbyte = merge_byte(state_reg.enable_reg, state_reg.w_data, state_reg.w_strb);
                state_next.enable_reg = wbyte;
            end else if (idx == link_tx_regs_pkg::manual_sync_request_index) begin
                wbyte = merge_byte(state_reg.manual_reg, state_reg.w_data, state_reg.w_strb);
                state_next.manual_reg = wbyte; // RL1
            end else if (idx == link_tx_regs_pkg::link_control_index) begin
                wbyte = merge_byte(state_reg.control_reg, state_reg.w_data, state_reg.w_strb);
                state_next.control_reg = wbyte; // RL4 RL5 RL6
            end else if (idx == link_tx_regs_pkg::test_pattern_control_index) begin
                wbyte = merge_byte(state_reg.pattern_reg, state_reg.w_data, state_reg.w_strb);
                state_next.pattern_reg = wbyte; // RL8 RL9 RL10 RL11
            end else if (idx == link_tx_regs_pkg::device_id_parameter_index) begin
                wbyte = merge_byte(state_reg.did_reg, state_reg.w_data, state_reg.w_strb);
                state_next.did_reg = {wbyte[7:1], 1'b0}; // RL15
            end else if (idx == link_tx_regs_pkg::frame_end_character_index) begin
                wbyte = merge_byte(state_reg.end_of_frame_char_select_reg, state_reg.w_data, state_reg.w_strb);
                state_next.end_of_frame_char_select_reg = wbyte; // RL16
            end else begin
                hit = 1'b0;
            end
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = hit ? resp_okay : resp_slverr;
        end

        if (s_axi_rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            idx = word_index(s_axi_araddr);
            hit = 1'b1;
            if (idx == link_tx_regs_pkg::link_enable_index) begin
                rbyte = state_reg.enable_reg;
            end else if (idx == link_tx_regs_pkg::manual_sync_request_index) begin
                rbyte = state_reg.manual_reg;
            end else if (idx == link_tx_regs_pkg::link_control_index) begin
                rbyte = state_reg.control_reg;
            end else if (idx == link_tx_regs_pkg::test_pattern_control_index) begin
                rbyte = state_reg.pattern_reg;
            end else if (idx == link_tx_regs_pkg::device_id_parameter_index) begin
                rbyte = state_reg.did_reg; // RL15
            end else if (idx == link_tx_regs_pkg::frame_end_character_index) begin
                rbyte = state_reg.end_of_frame_char_select_reg;
            end else begin
                hit = 1'b0;
            end
            state_next.rvalid = 1'b1;
            state_next.rdata = {24'h000000, rbyte};
            state_next.rresp = hit ? resp_okay : resp_slverr;
        end

        if (!aresetn) begin
            state_next = '0;
            state_next.enable_reg = link_tx_regs_pkg::link_enable_reset;
            state_next.manual_reg = link_tx_regs_pkg::manual_sync_request_reset;
            state_next.control_reg = link_tx_regs_pkg::link_control_reset;
            state_next.pattern_reg = link_tx_regs_pkg::test_pattern_control_reset;
            state_next.did_reg = link_tx_regs_pkg::device_id_parameter_reset;
            state_next.end_of_frame_char_select_reg = link_tx_regs_pkg::frame_end_character_reset;
            state_next.sync_n = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        state_reg <= state_next;
    end

    assign s_axi_awready = !state_reg.aw_held;
    assign s_axi_wready = !state_reg.w_held;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // While the link is disabled the transmitter stays in reset and powered down.
    assign link_enable = state_reg.enable_reg[link_tx_regs_pkg::link_enable_pos];
    assign transmitter_reset = !link_enable; // RL17
    assign serializer_power_down = !link_enable; // RL17
    assign tx_clock_gate_off = !link_enable; // RL17
    assign multiframe_counter_reset = !link_enable; // RL17
    assign sync_request_n = state_reg.sync_n; // RL18
    assign sample_format = state_reg.control_reg[link_tx_regs_pkg::sample_format_pos]; // RL5
    assign scrambler_enable = state_reg.control_reg[link_tx_regs_pkg::scrambler_enable_pos]; // RL6
    assign test_pattern_select = state_reg.pattern_reg[link_tx_regs_pkg::test_pattern_lsb +: 4];
    assign test_pattern_reserved = test_pattern_select > link_tx_regs_pkg::pat_hold_high; // RL12
    assign link_a_device_identifier = state_reg.did_reg; // RL13 RL14
    assign link_b_device_identifier = 8'(state_reg.did_reg + 8'h01); // RL14
    assign end_of_frame_char = end_of_frame_char_select_code;
    assign end_of_frame_char_reserved = end_of_frame_char_select_reserved;
endmodule
`default_nettype wire

// >>> testbench/link_tx_regs_sva.sv
// Checker for the ports of the link control register bank.
`timescale 1ns/1ps
`default_nettype none
module link_tx_regs_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Transmitter controls
    input wire logic link_enable,
    input wire logic transmitter_reset,
    input wire logic serializer_power_down,
    input wire logic tx_clock_gate_off,
    input wire logic multiframe_counter_reset,
    input wire logic sync_request_n,
    input wire logic sample_format,
    input wire logic scrambler_enable,
    input wire logic [3:0] test_pattern_select,
    input wire logic test_pattern_reserved,
    input wire logic [7:0] link_a_device_identifier,
    input wire logic [7:0] link_b_device_identifier,
    input wire logic [7:0] end_of_frame_char,
    input wire logic end_of_frame_char_reserved
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    sequence b_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("Read answer missing.");
    read_hold_a: assert property (r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read answer dropped.");
    write_hold_a: assert property (b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write answer dropped.");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Second read accepted.");
    hold_reset_a: assert property (
        {transmitter_reset, serializer_power_down, tx_clock_gate_off,
        multiframe_counter_reset} == {4{!link_enable}})
        else $error("Hold outputs disagree with enable.");
    link_b_a: assert property (link_b_device_identifier == link_a_device_identifier + 8'h01)
        else $error("Second identifier wrong.");
    id_even_a: assert property (!link_a_device_identifier[0])
        else $error("Identifier low bit set.");
    pat_rsvd_a: assert property (test_pattern_reserved == (test_pattern_select > 4'hb))
        else $error("Pattern reserved flag wrong.");
    end_of_frame_char_select_rsvd_a: assert property (end_of_frame_char_reserved |-> end_of_frame_char == 8'hfc)
        else $error("Reserved frame code character wrong.");
    reset_vals_a: assert property ($rose(aresetn) |-> sample_format && !scrambler_enable
        && link_enable && sync_request_n && test_pattern_select == 4'h0)
        else $error("Reset values wrong.");
endmodule
bind serial_link_tx_control_regs link_tx_regs_sva u_sva (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .link_enable,
    .transmitter_reset, .serializer_power_down, .tx_clock_gate_off,
    .multiframe_counter_reset, .sync_request_n, .sample_format, .scrambler_enable,
    .test_pattern_select, .test_pattern_reserved, .link_a_device_identifier,
    .link_b_device_identifier, .end_of_frame_char, .end_of_frame_char_reserved
);
`default_nettype wire

// >>> testbench/link_rx_model.sv
// Behavioural link receiver that drives the active-low sync pins.
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
    // Clock
    input wire logic aclk,
    // Bench requests
    input wire logic want_pin,
    input wire logic want_stamp,
    // Active-low sync pins
    output var logic single_ended_sync_pin_n = 1'b1,
    output var logic differential_timestamp_input_n = 1'b1
);
    always @(posedge aclk) begin
        single_ended_sync_pin_n <= !want_pin;
        differential_timestamp_input_n <= !want_stamp;
    end
endmodule
`default_nettype wire

// >>> testbench/test_serial_link_tx_control_regs.sv
// Self-checking bench for the link control register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module test_serial_link_tx_control_regs;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic want_pin = 1'b0, want_stamp = 1'b0, timestamp_receiver_enable = 1'b0;
    logic single_ended_sync_pin_n, differential_timestamp_input_n;
    logic link_enable, transmitter_reset, serializer_power_down, tx_clock_gate_off;
    logic multiframe_counter_reset, sync_request_n, sample_format, scrambler_enable;
    logic test_pattern_reserved, end_of_frame_char_reserved;
    logic [3:0] test_pattern_select;
    logic [7:0] link_a_device_identifier, link_b_device_identifier, end_of_frame_char;
    int n_mismatch = 0;
    int comparisons = 0;
    // Each case: select, manual bit, pin, stamp pin, stamp enable, expected request.
    logic [6:0] sync_case [9] = '{7'b00_1_1_0_0_0, 7'b00_1_0_0_0_1, 7'b10_1_1_0_0_1,
        7'b10_0_0_0_0_0, 7'b01_1_0_1_1_0, 7'b01_1_0_1_0_1, 7'b01_0_1_0_0_0, 7'b00_1_0_1_1_1,
        7'b11_1_1_0_0_1};
    initial begin
        forever #5 aclk = ~aclk;
    end
    serial_link_tx_control_regs dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .single_ended_sync_pin_n,
        .differential_timestamp_input_n, .timestamp_receiver_enable, .link_enable,
        .transmitter_reset, .serializer_power_down, .tx_clock_gate_off,
        .multiframe_counter_reset, .sync_request_n, .sample_format, .scrambler_enable,
        .test_pattern_select, .link_a_device_identifier, .link_b_device_identifier,
        .end_of_frame_char, .end_of_frame_char_reserved, .test_pattern_reserved
    );
    link_rx_model partner (.aclk, .want_pin, .want_stamp, .single_ended_sync_pin_n,
        .differential_timestamp_input_n);
    function automatic logic [7:0] frame_char(input logic [1:0] c);
        return (c == 2'h1) ? 8'h3c : (c == 2'h2) ? 8'hbc : 8'hfc;
    endfunction
    task automatic summarize;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic xfer(input bit w, input logic [11:0] idx, input logic [7:0] d,
            output logic [31:0] q, output logic [1:0] r);
        int n;
        int lag;
        bit done;
        n = 0;
        done = 1'b0;
        q = '0;
        r = '0;
        // A random lag before the answer is accepted lets the slave hold its answer.
        lag = 1 + int'($urandom_range(3));
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= {idx, 2'b00};
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
        end else begin
            s_axi_araddr <= {idx, 2'b00};
            s_axi_arvalid <= 1'b1;
        end
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                done = 1'b1;
                r = s_axi_rresp;
                q = s_axi_rdata;
                s_axi_rready <= 1'b0;
            end
            if (n == lag) begin
                if (w) s_axi_bready <= 1'b1;
                else s_axi_rready <= 1'b1;
            end
        end
        if (!done) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b1, idx, d, q, r);
        `CHK(r, 2'h0)
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b0, idx, 8'h00, q, r);
        `CHK(q, e)
        `CHK(r, er)
    endtask
    initial begin
        logic [7:0] d;
        logic [39:0] reset_vals;
        reset_vals = 40'h0000000201;
        void'($urandom(15));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h200, 32'h1, 2'h0);
        `CHK(transmitter_reset, 1'b0)
        for (int i = 0; i < 5; i++) begin
            rd(12'(12'h203 + i), {24'h0, reset_vals[8*i +: 8]}, 2'h0);
        end
        wr(12'h200, 8'h00);
        `CHK(multiframe_counter_reset, 1'b1)
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            if (i == 2) d[3] = 1'b0;
            if (i == 3) d[0] = 1'b1;
            wr(12'(12'h203 + i), d);
            if (i == 3) d[0] = 1'b0;
            rd(12'(12'h203 + i), {24'h0, d}, 2'h0);
            if (i == 3) begin
                `CHK(link_a_device_identifier, d)
                `CHK(link_b_device_identifier, d + 8'h01)
            end
        end
        for (int i = 0; i < 16; i++) begin
            wr(12'h205, 8'(i));
            `CHK(test_pattern_select, 4'(i))
            `CHK(test_pattern_reserved, (i > 11))
        end
        for (int i = 0; i < 4; i++) begin
            wr(12'h207, 8'(i));
            `CHK(end_of_frame_char, frame_char(2'(i)))
            `CHK(end_of_frame_char_reserved, (i == 3))
        end
        d = 8'($urandom);
        wr(12'h204, {6'h02, d[1:0]});
        `CHK(sample_format, d[1])
        `CHK(scrambler_enable, d[0])
        foreach (sync_case[i]) begin
            want_pin <= sync_case[i][3];
            want_stamp <= sync_case[i][2];
            timestamp_receiver_enable <= sync_case[i][1];
            wr(12'h204, {4'h0, sync_case[i][6:5], 2'b10});
            wr(12'h203, {7'h0, sync_case[i][4]});
            repeat (6) @(posedge aclk);
            `CHK(sync_request_n, sync_case[i][0])
        end
        rd(12'h210, 32'h0, 2'h2);
        wr(12'h200, 8'h01);
        `CHK(transmitter_reset, 1'b0)
        summarize();
    end
endmodule
`default_nettype wire
